// ### hdl/rss_pkg.sv
// package: opcodes, field layout, reset values and cycle counts for the exec block
package rss_pkg;
  typedef enum logic [2:0] {
    RSS_OP_NONE,
    RSS_OP_ROT_RIGHT,
    RSS_OP_ROT_LEFT,
    RSS_OP_SUB_LIT,
    RSS_OP_RET_LIT,
    RSS_OP_SLEEP
  } rss_op_t;

  localparam int          RSS_DATA_W      = 8;
  localparam int          RSS_ADDR_W      = 7;
  localparam int          RSS_PC_W        = 15;
  localparam int          RSS_NIB_MSB     = 3;
  localparam logic [7:0]  RSS_W_RST       = 8'h00;
  localparam logic [14:0] RSS_PC_RST      = 15'h0000;
  localparam logic        RSS_PD_RST      = 1'h1;
  localparam logic        RSS_TO_RST      = 1'h1;
  localparam logic        RSS_DEST_W      = 1'h0;
  localparam logic        RSS_DEST_F      = 1'h1;
  localparam logic [1:0]  RSS_RET_CYCLES  = 2'h2;
endpackage : rss_pkg

// ### hdl/rss_alu.sv
// combinational datapath: rotates and literal subtract with flags
module rss_alu
  import rss_pkg::*;
#(
  parameter int DATA_W = RSS_DATA_W
)
(
  // operands
  input  wire logic [DATA_W-1:0] i_src,
  input  wire logic [DATA_W-1:0] i_wreg,
  input  wire logic [DATA_W-1:0] i_lit,
  input  wire logic              i_carry,
  input  wire rss_op_t           i_op,
  // results
  output logic      [DATA_W-1:0] o_res,
  output logic                   o_carry,
  output logic                   o_dcarry,
  output logic                   o_zero
);
  // rotate taps and nibble borrow assume a byte-wide datapath
  if (DATA_W != 8)
  begin : g_width_check
    $error("rss_alu supports 8-bit data only");
  end

  logic [DATA_W:0] diff;
  logic [4:0]      ndiff;

  always_comb
  begin
    diff     = {1'b0, i_lit} - {1'b0, i_wreg};
    ndiff    = {1'b0, i_lit[RSS_NIB_MSB:0]} - {1'b0, i_wreg[RSS_NIB_MSB:0]};
    o_res    = i_src;
    o_carry  = i_carry;
    o_dcarry = 1'b0;
    o_zero   = 1'b0;
    case (i_op)
      RSS_OP_ROT_RIGHT:
      begin
        o_res   = {i_carry, i_src[DATA_W-1:1]};
        o_carry = i_src[0];
      end
      RSS_OP_ROT_LEFT:
      begin
        o_res   = {i_src[DATA_W-2:0], i_carry};
        o_carry = i_src[DATA_W-1];
      end
      RSS_OP_SUB_LIT:
      begin
        o_res    = diff[DATA_W-1:0];
        o_carry  = ~diff[DATA_W];
        o_dcarry = ~ndiff[4];
        o_zero   = (diff[DATA_W-1:0] == '0);
      end
      default:
      begin
        o_res = i_src;
      end
    endcase
  end
endmodule : rss_alu

// ### hdl/rss_exec.sv
// execution unit for rotate, literal subtract, literal return and sleep
// Notes on behaviour
// - rotate right: carry into bit 7, bit 0 out to carry
// - rotate dest 0 writes working reg; dest 1 writes file register 0..127
// - literal subtract: literal minus working reg into working reg, flags updated
// - carry 0 if working reg above literal; digit carry likewise on low nibble
// - sleep clears active-low power-down flag
// - sleep sets active-low timeout flag
// - sleep clears watchdog counter and prescaler
// - after sleep updates, execution halts and oscillator stops
// - rotate left: carry into bit 0, bit 7 out to carry
// - literal return loads working reg from literal and pc from stack top
// - literal return takes two cycles, flushing the fetched word
module rss_exec
  import rss_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // decoded instruction
  input  wire logic                  i_valid,
  input  wire rss_op_t               i_op,
  input  wire logic [RSS_ADDR_W-1:0] i_addr,
  input  wire logic                  i_dest,
  input  wire logic [RSS_DATA_W-1:0] i_lit,
  // operand from file register read
  input  wire logic [RSS_DATA_W-1:0] i_file_rdata,
  // stack
  input  wire logic [RSS_PC_W-1:0]   i_stack_top,
  // wake from sleep
  input  wire logic                  i_wake,
  // file register write
  output logic                       o_file_we,
  output logic [RSS_ADDR_W-1:0]      o_file_addr,
  output logic [RSS_DATA_W-1:0]      o_file_wdata,
  // core state
  output logic [RSS_DATA_W-1:0]      o_wreg,
  output logic                       o_carry,
  output logic                       o_digit_carry,
  output logic                       o_zero,
  output logic                       o_power_down_flag,
  output logic                       o_timeout_flag,
  // control
  output logic                       o_watchdog_clr,
  output logic                       o_stack_pop,
  output logic [RSS_PC_W-1:0]        o_pc,
  output logic                       o_pc_load,
  output logic                       o_flush,
  output logic                       o_busy,
  output logic                       o_osc_stop
);
  typedef enum {RSS_ST_RUN, RSS_ST_RET2, RSS_ST_SLEEP} rss_state_t;

  rss_state_t              state_ff, nxt_state;
  logic [RSS_DATA_W-1:0]   w_ff, nxt_w;
  logic                    c_ff, nxt_c, dc_ff, nxt_dc, z_ff, nxt_z;
  logic                    pd_ff, nxt_pd, to_ff, nxt_to;
  logic                    fwe_ff, nxt_fwe;
  logic [RSS_ADDR_W-1:0]   fa_ff, nxt_fa;
  logic [RSS_DATA_W-1:0]   fd_ff, nxt_fd;
  logic                    wdc_ff, nxt_wdc, pop_ff, nxt_pop, pcl_ff, nxt_pcl, fl_ff, nxt_fl;
  logic [RSS_PC_W-1:0]     pc_ff, nxt_pc;
  logic                    busy_ff, nxt_busy, osc_ff, nxt_osc;
  logic [RSS_DATA_W-1:0]   alu_res;
  logic                    alu_c, alu_dc, alu_z;
  logic                    take;

  rss_alu #(
    .DATA_W (RSS_DATA_W)
  ) u_alu (
    .i_src    (i_file_rdata),
    .i_wreg   (w_ff),
    .i_lit    (i_lit),
    .i_carry  (c_ff),
    .i_op     (i_op),
    .o_res    (alu_res),
    .o_carry  (alu_c),
    .o_dcarry (alu_dc),
    .o_zero   (alu_z)
  );

  assign take = i_valid && (state_ff == RSS_ST_RUN);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_w     = w_ff;
    nxt_c     = c_ff;
    nxt_dc    = dc_ff;
    nxt_z     = z_ff;
    nxt_pd    = pd_ff;
    nxt_to    = to_ff;
    nxt_fwe   = 1'b0;
    nxt_fa    = fa_ff;
    nxt_fd    = fd_ff;
    nxt_wdc   = 1'b0;
    nxt_pop   = 1'b0;
    nxt_pcl   = 1'b0;
    nxt_fl    = 1'b0;
    nxt_pc    = pc_ff;
    nxt_busy  = 1'b0;
    nxt_osc   = osc_ff;
    case (state_ff)
      RSS_ST_RUN:
      begin
        if (take)
        begin
          case (i_op)
            RSS_OP_ROT_RIGHT, RSS_OP_ROT_LEFT:
            begin
              nxt_c = alu_c;
              if (i_dest == RSS_DEST_F)
              begin
                nxt_fwe = 1'b1;
                nxt_fa  = i_addr;
                nxt_fd  = alu_res;
              end
              else
              begin
                nxt_w = alu_res;
              end
            end
            RSS_OP_SUB_LIT:
            begin
              nxt_w  = alu_res;
              nxt_c  = alu_c;
              nxt_dc = alu_dc;
              nxt_z  = alu_z;
            end
            RSS_OP_RET_LIT:
            begin
              nxt_w     = i_lit;
              nxt_pc    = i_stack_top;
              nxt_pcl   = 1'b1;
              nxt_pop   = 1'b1;
              nxt_fl    = 1'b1;
              nxt_busy  = 1'b1;
              nxt_state = RSS_ST_RET2;
            end
            RSS_OP_SLEEP:
            begin
              nxt_pd    = 1'b0;
              nxt_to    = 1'b1;
              nxt_wdc   = 1'b1;
              nxt_osc   = 1'b1;
              nxt_busy  = 1'b1;
              nxt_state = RSS_ST_SLEEP;
            end
            default:
            begin
              nxt_state = RSS_ST_RUN;
            end
          endcase
        end
      end
      RSS_ST_RET2:
      begin
        // second cycle: fetched word discarded
        nxt_state = RSS_ST_RUN;
      end
      RSS_ST_SLEEP:
      begin
        nxt_busy = 1'b1;
        if (i_wake)
        begin
          nxt_osc   = 1'b0;
          nxt_busy  = 1'b0;
          nxt_state = RSS_ST_RUN;
        end
      end
      default:
      begin
        nxt_state = RSS_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_ff <= RSS_ST_RUN;
      w_ff     <= RSS_W_RST;
      c_ff     <= 1'b0;
      dc_ff    <= 1'b0;
      z_ff     <= 1'b0;
      pd_ff    <= RSS_PD_RST;
      to_ff    <= RSS_TO_RST;
      fwe_ff   <= 1'b0;
      fa_ff    <= '0;
      fd_ff    <= '0;
      wdc_ff   <= 1'b0;
      pop_ff   <= 1'b0;
      pcl_ff   <= 1'b0;
      fl_ff    <= 1'b0;
      pc_ff    <= RSS_PC_RST;
      busy_ff  <= 1'b0;
      osc_ff   <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      w_ff     <= nxt_w;
      c_ff     <= nxt_c;
      dc_ff    <= nxt_dc;
      z_ff     <= nxt_z;
      pd_ff    <= nxt_pd;
      to_ff    <= nxt_to;
      fwe_ff   <= nxt_fwe;
      fa_ff    <= nxt_fa;
      fd_ff    <= nxt_fd;
      wdc_ff   <= nxt_wdc;
      pop_ff   <= nxt_pop;
      pcl_ff   <= nxt_pcl;
      fl_ff    <= nxt_fl;
      pc_ff    <= nxt_pc;
      busy_ff  <= nxt_busy;
      osc_ff   <= nxt_osc;
    end
  end

  assign o_file_we         = fwe_ff;
  assign o_file_addr       = fa_ff;
  assign o_file_wdata      = fd_ff;
  assign o_wreg            = w_ff;
  assign o_carry           = c_ff;
  assign o_digit_carry     = dc_ff;
  assign o_zero            = z_ff;
  assign o_power_down_flag = pd_ff;
  assign o_timeout_flag    = to_ff;
  assign o_watchdog_clr    = wdc_ff;
  assign o_stack_pop       = pop_ff;
  assign o_pc              = pc_ff;
  assign o_pc_load         = pcl_ff;
  assign o_flush           = fl_ff;
  assign o_busy            = busy_ff;
  assign o_osc_stop        = osc_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_sleep_taken;
    take && i_op == RSS_OP_SLEEP;
  endsequence
  sequence s_ret_taken;
    take && i_op == RSS_OP_RET_LIT;
  endsequence

  AST_RR_SHIFT: assert property (take && i_op == RSS_OP_ROT_RIGHT && i_dest == RSS_DEST_W |=>
    w_ff == {$past(c_ff), $past(i_file_rdata[7:1])} && c_ff == $past(i_file_rdata[0]))
    else $error("rotate right result wrong");
  AST_RL_SHIFT: assert property (take && i_op == RSS_OP_ROT_LEFT && i_dest == RSS_DEST_W |=>
    w_ff == {$past(i_file_rdata[6:0]), $past(c_ff)} && c_ff == $past(i_file_rdata[7]))
    else $error("rotate left result wrong");
  AST_ROT_DEST_F: assert property (take && (i_op == RSS_OP_ROT_RIGHT || i_op == RSS_OP_ROT_LEFT)
    && i_dest == RSS_DEST_F |=> o_file_we && o_file_addr == $past(i_addr) && $stable(w_ff))
    else $error("rotate to file register wrong");
  AST_SUB_RES: assert property (take && i_op == RSS_OP_SUB_LIT |=>
    w_ff == 8'($past(i_lit) - $past(w_ff)) && z_ff == (w_ff == 8'h00))
    else $error("literal subtract result wrong");
  AST_SUB_C: assert property (take && i_op == RSS_OP_SUB_LIT |=>
    c_ff == ($past(w_ff) <= $past(i_lit)) && dc_ff == ($past(w_ff[3:0]) <= $past(i_lit[3:0])))
    else $error("literal subtract carries wrong");
  AST_SLEEP_PD: assert property (s_sleep_taken |=> !o_power_down_flag)
    else $error("power-down flag not cleared");
  AST_SLEEP_TO: assert property (s_sleep_taken |=> o_timeout_flag)
    else $error("timeout flag not set");
  AST_SLEEP_WDT: assert property (s_sleep_taken |=> o_watchdog_clr ##1 !o_watchdog_clr)
    else $error("watchdog clear pulse wrong");
  AST_SLEEP_HALT: assert property (s_sleep_taken ##1 !i_wake |=> o_osc_stop && o_busy)
    else $error("sleep did not halt");
  AST_RET_LOAD: assert property (s_ret_taken |=> o_pc == $past(i_stack_top) && w_ff == $past(i_lit))
    else $error("literal return load wrong");
  AST_RET_TWO: assert property (s_ret_taken |=> o_flush ##1 (state_ff == RSS_ST_RUN && !o_flush))
    else $error("literal return not two cycles");
endmodule : rss_exec

// ### tb/rotate_subtract_sleep_exec_bench.sv
// self-checking bench for the rotate, literal subtract, literal return and sleep unit
module rotate_subtract_sleep_exec_bench
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  i_clk;
  logic                  i_sys_rst;
  logic                  i_valid;
  rss_op_t               i_op;
  logic [RSS_ADDR_W-1:0] i_addr;
  logic                  i_dest;
  logic [RSS_DATA_W-1:0] i_lit;
  logic [RSS_DATA_W-1:0] i_file_rdata;
  logic [RSS_PC_W-1:0]   i_stack_top;
  logic                  i_wake;
  logic                  o_file_we;
  logic [RSS_ADDR_W-1:0] o_file_addr;
  logic [RSS_DATA_W-1:0] o_file_wdata;
  logic [RSS_DATA_W-1:0] o_wreg;
  logic                  o_carry;
  logic                  o_digit_carry;
  logic                  o_zero;
  logic                  o_power_down_flag;
  logic                  o_timeout_flag;
  logic                  o_watchdog_clr;
  logic                  o_stack_pop;
  logic [RSS_PC_W-1:0]   o_pc;
  logic                  o_pc_load;
  logic                  o_flush;
  logic                  o_busy;
  logic                  o_osc_stop;
  int                    miscompares;
  int                    num_checks;

  rss_exec u_rss_exec (
    .i_clk             (i_clk),
    .i_sys_rst         (i_sys_rst),
    .i_valid           (i_valid),
    .i_op              (i_op),
    .i_addr            (i_addr),
    .i_dest            (i_dest),
    .i_lit             (i_lit),
    .i_file_rdata      (i_file_rdata),
    .i_stack_top       (i_stack_top),
    .i_wake            (i_wake),
    .o_file_we         (o_file_we),
    .o_file_addr       (o_file_addr),
    .o_file_wdata      (o_file_wdata),
    .o_wreg            (o_wreg),
    .o_carry           (o_carry),
    .o_digit_carry     (o_digit_carry),
    .o_zero            (o_zero),
    .o_power_down_flag (o_power_down_flag),
    .o_timeout_flag    (o_timeout_flag),
    .o_watchdog_clr    (o_watchdog_clr),
    .o_stack_pop       (o_stack_pop),
    .o_pc              (o_pc),
    .o_pc_load         (o_pc_load),
    .o_flush           (o_flush),
    .o_busy            (o_busy),
    .o_osc_stop        (o_osc_stop)
  );

  initial
  begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk_v(input logic [14:0] got, input logic [14:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_b(input logic got, input logic exp);
    chk_v({14'h0000, got}, {14'h0000, exp});
  endtask : chk_b

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // one instruction; follow keeps a literal subtract pending in the next cycle
  task automatic issue(input rss_op_t op, input logic [6:0] addr, input logic dest, input logic [7:0] lit,
                       input logic [7:0] frd, input logic [14:0] stk, input logic follow);
    @(posedge i_clk);
    i_valid      <= 1'h1;
    i_op         <= op;
    i_addr       <= addr;
    i_dest       <= dest;
    i_lit        <= lit;
    i_file_rdata <= frd;
    i_stack_top  <= stk;
    @(posedge i_clk);
    if (follow)
    begin
      i_op  <= RSS_OP_SUB_LIT;
      i_lit <= 8'h33;
    end
    else
      i_valid <= 1'h0;
    #1;
  endtask : issue

  task automatic test_rotate;
    issue(RSS_OP_ROT_LEFT, 7'h05, RSS_DEST_W, 8'h00, 8'hE6, 15'h0000, 1'h0);
    chk_v(o_wreg, 8'hCC);
    chk_b(o_carry, 1'h1);
    chk_b(o_file_we, 1'h0);
    issue(RSS_OP_ROT_RIGHT, 7'h7F, RSS_DEST_F, 8'h00, 8'h55, 15'h0000, 1'h0);
    chk_b(o_file_we, 1'h1);
    chk_v(o_file_addr, 7'h7F);
    chk_v(o_file_wdata, 8'hAA);
    chk_b(o_carry, 1'h1);
    chk_v(o_wreg, 8'hCC);
    issue(RSS_OP_ROT_RIGHT, 7'h10, RSS_DEST_W, 8'h00, 8'h02, 15'h0000, 1'h0);
    chk_b(o_file_we, 1'h0);
    chk_v(o_wreg, 8'h81);
    chk_b(o_carry, 1'h0);
    issue(RSS_OP_ROT_LEFT, 7'h00, RSS_DEST_F, 8'h00, 8'h80, 15'h0000, 1'h0);
    chk_v(o_file_addr, 7'h00);
    chk_v(o_file_wdata, 8'h00);
    chk_b(o_carry, 1'h1);
    chk_v(o_wreg, 8'h81);
    $display("test rotate done");
  endtask : test_rotate

  task automatic test_subtract;
    logic [7:0] lits [4];
    logic [7:0] exp_w;
    logic [7:0] res;
    lits  = '{8'h81, 8'h10, 8'h0F, 8'h05};
    exp_w = 8'h81;
    foreach (lits[i])
    begin
      res = lits[i] - exp_w;
      issue(RSS_OP_SUB_LIT, 7'h00, RSS_DEST_W, lits[i], 8'h00, 15'h0000, 1'h0);
      chk_v(o_wreg, res);
      chk_b(o_carry, exp_w <= lits[i]);
      chk_b(o_digit_carry, exp_w[3:0] <= lits[i][3:0]);
      chk_b(o_zero, res == 8'h00);
      exp_w = res;
    end
    $display("test subtract done");
  endtask : test_subtract

  task automatic test_return;
    issue(RSS_OP_RET_LIT, 7'h00, RSS_DEST_W, 8'h5A, 8'h00, 15'h4321, 1'h1);
    chk_v(o_wreg, 8'h5A);
    chk_v(o_pc, 15'h4321);
    chk_b(o_pc_load, 1'h1);
    chk_b(o_stack_pop, 1'h1);
    chk_b(o_flush, 1'h1);
    chk_b(o_busy, 1'h1);
    @(posedge i_clk);
    i_valid <= 1'h0;
    #1;
    chk_v(o_wreg, 8'h5A);
    chk_b(o_pc_load, 1'h0);
    chk_b(o_busy, 1'h0);
    $display("test return done");
  endtask : test_return

  task automatic test_sleep;
    bit woke;
    issue(RSS_OP_SLEEP, 7'h00, RSS_DEST_W, 8'h00, 8'h00, 15'h0000, 1'h1);
    chk_b(o_power_down_flag, 1'h0);
    chk_b(o_timeout_flag, 1'h1);
    chk_b(o_watchdog_clr, 1'h1);
    chk_b(o_osc_stop, 1'h1);
    chk_b(o_busy, 1'h1);
    @(posedge i_clk);
    i_valid <= 1'h0;
    #1;
    chk_b(o_watchdog_clr, 1'h0);
    chk_v(o_wreg, 8'h5A);
    chk_b(o_osc_stop, 1'h1);
    @(posedge i_clk);
    i_wake <= 1'h1;
    woke = 1'b0;
    repeat (4)
    begin
      @(posedge i_clk);
      i_wake <= 1'h0;
      #1;
      if (o_busy === 1'h0 && !woke)
        woke = 1'b1;
    end
    chk_b(woke, 1'h1);
    chk_b(o_osc_stop, 1'h0);
    chk_b(o_power_down_flag, 1'h0);
    $display("test sleep done");
  endtask : test_sleep

  initial
  begin
    miscompares  = 0;
    num_checks   = 0;
    i_sys_rst    = 1'h1;
    i_valid      = 1'h0;
    i_op         = RSS_OP_NONE;
    i_addr       = 7'h00;
    i_dest       = 1'h0;
    i_lit        = 8'h00;
    i_file_rdata = 8'h00;
    i_stack_top  = 15'h0000;
    i_wake       = 1'h0;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    #1;
    chk_v(o_wreg, RSS_W_RST);
    chk_b(o_power_down_flag, RSS_PD_RST);
    chk_b(o_timeout_flag, RSS_TO_RST);
    chk_b(o_busy, 1'h0);
    test_rotate();
    test_subtract();
    test_return();
    test_sleep();
    print_verdict();
  end
endmodule : rotate_subtract_sleep_exec_bench
